/* File: hdl/rscg_top.sv */
// Reset, strap sampling, configuration store loader and pin function map
//
// Functional notes
// - After reset release the device runs from its defined default configuration.
// - After 50 ms the strap pins become ordinary general purpose pins.
// - All clock outputs come up disabled unless the image or software enables them, or a high pin 2 enables the first.
// - High level on pin 2 enables the first differential output without software while pin 2 has function code 0x00.
// - Configuration store holds 253 byte-wide registers.
// - Store values come from defaults, one-time-programmable image or host writes.
// - At power-up the one-time-programmable image is copied into the store when otp_custom is high.
// - Host rewrites store while running and new settings take effect.
// - Pin control function is chosen by bits 6:0 of its configuration register.
// - Function code 0x00 makes the pin a plain input with no function, except on pin 2, where it enables the first output.
// - Codes 0x10,0x14,0x18,0x1C make the pin a signal-loss input for refs 0-3.
// - Pin set as host interrupt output flags device status changes.
// - Pins 1:0 at start-up pick master clock; 3 means 24.576 MHz, others reserved.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module rscg_top
	import rscg_pkg::*;
#(
	parameter int STRAP_CYCLES = STRAP_HOLD_CYCLES,
	parameter int NUM_GPIO = 6
) (
	// Clock and synchronous reset (inverted power reset)
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus
	input wire rscg_pkg::rscg_apb_req_t apb_req,
	output rscg_pkg::rscg_apb_rsp_t apb_rsp,
	// Image memory read port, data valid in the cycle the address is shown
	input wire logic otp_custom,
	output logic [7:0] otp_addr,
	input wire logic [7:0] otp_rdata,
	// General purpose pins
	input wire logic [NUM_GPIO-1:0] gpio_in,
	output logic [NUM_GPIO-1:0] gpio_out,
	output logic [NUM_GPIO-1:0] gpio_oe,
	// Block outputs
	output logic [7:0] first_hp_diff_output,
	output logic [NUM_REFS-1:0] signal_absent_flag,
	output logic config_ready,
	output logic strap_window,
	output logic [NUM_GPIO-1:0] strap_bits,
	output logic mclk_valid,
	output logic irq
);
	import rscg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Built-in default value of one store register
	function automatic logic [7:0] default_value(input logic [7:0] idx);
		default_value = (idx == OUT_EN_IDX) ? STORE_RST_VAL : STORE_RST_VAL;
	endfunction

	// Pin function code of a pin from the store
	function automatic logic [6:0] pin_func(input logic [7:0] cfg);
		pin_func = cfg[GPIO_FUNC_MSB:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0] store [0:STORE_DEPTH-1];
	rscg_ld_state_t ld_state, next_ld_state;
	logic [7:0] ld_idx, next_ld_idx;
	logic [7:0] next_otp_addr;
	logic ld_wr, next_ld_wr;
	logic [STRAP_CNT_W-1:0] strap_cnt, next_strap_cnt;
	logic next_strap_window;
	logic [NUM_GPIO-1:0] next_strap_bits;
	logic next_mclk_valid;
	logic [7:0] irq_status, next_irq_status;
	logic [7:0] irq_mask, next_irq_mask;
	logic [7:0] next_first_hp_diff_output;
	logic [NUM_REFS-1:0] next_signal_absent_flag;
	logic [NUM_GPIO-1:0] next_gpio_out, next_gpio_oe;
	logic [31:0] prdata_q, next_prdata;
	logic running;
	logic acc, host_wr, store_hit, own_hit;
	logic [7:0] host_idx;
	logic [7:0] ld_src;
	logic [7:0] irq_set;

	assign running = (ld_state == LD_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Loader: fills the store from image or defaults after reset
	// The byte shown on otp_addr is stored at the following edge
	always_comb begin
		next_ld_state = ld_state;
		next_ld_idx = ld_idx;
		next_otp_addr = otp_addr;
		next_ld_wr = 1'b0;
		case (ld_state)
			LD_FETCH: begin
				next_otp_addr = ld_idx;
				next_ld_wr = 1'b1;
				next_ld_idx = ld_idx + 8'h01;
				if (ld_idx == STORE_LAST_IDX) begin
					next_ld_state = LD_LAST;
				end
			end
			LD_LAST: begin
				next_ld_state = LD_RUN;
			end
			LD_RUN: begin
				next_ld_state = LD_RUN;
			end
			default: begin
				next_ld_state = LD_FETCH;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ld_state <= LD_FETCH;
			ld_idx <= 8'h00;
			otp_addr <= 8'h00;
			ld_wr <= 1'b0;
		end else begin
			ld_state <= next_ld_state;
			ld_idx <= next_ld_idx;
			otp_addr <= next_otp_addr;
			ld_wr <= next_ld_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Store writes: loader first, then host
	assign acc = apb_req.psel && apb_req.penable;
	assign host_idx = apb_req.paddr[9:2];
	// Indices 253 to 255 lie outside the store and answer with an error
	assign store_hit = (apb_req.paddr[11:10] == 2'b00) && (host_idx <= STORE_LAST_IDX);
	assign own_hit = (apb_req.paddr == IRQ_STATUS_ADDR) || (apb_req.paddr == IRQ_MASK_ADDR) ||
		(apb_req.paddr == STRAP_STAT_ADDR);
	assign host_wr = acc && running && apb_req.pwrite && store_hit;
	assign ld_src = otp_custom ? otp_rdata : default_value(otp_addr);

	always_ff @(posedge ref_clk) begin
		// Loader writes first; host writes are held off until it finishes
		if (ld_wr) begin
			store[otp_addr] <= ld_src;
		end else if (host_wr) begin
			store[host_idx] <= apb_req.pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap window: counts the hold time and latches straps once at its end
	always_comb begin
		next_strap_cnt = strap_cnt;
		next_strap_window = strap_window;
		next_strap_bits = strap_bits;
		next_mclk_valid = mclk_valid;
		// Counting stops once the window closes, so the counter never wraps
		if (strap_window) begin
			next_strap_cnt = strap_cnt + 1'b1;
			if (strap_cnt == STRAP_CNT_W'(STRAP_CYCLES - 1)) begin
				next_strap_window = 1'b0;
				next_strap_bits = gpio_in;
				next_mclk_valid = (gpio_in[1:0] == MCLK_SEL_24M576);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strap_cnt <= '0;
			strap_window <= 1'b1;
			strap_bits <= '0;
			mclk_valid <= 1'b0;
		end else begin
			strap_cnt <= next_strap_cnt;
			strap_window <= next_strap_window;
			strap_bits <= next_strap_bits;
			mclk_valid <= next_mclk_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin functions, output enables and signal-loss inputs
	always_comb begin
		logic [6:0] f;
		logic pin2_en;
		f = FUNC_PLAIN_INPUT;
		pin2_en = 1'b0;
		next_signal_absent_flag = '0;
		next_gpio_out = '0;
		next_gpio_oe = '0;
		next_first_hp_diff_output = '0;
		if (running) begin
			for (int i = 0; i < NUM_GPIO; i++) begin
				// Bit 7 of a pin register takes no part in the decode
				f = pin_func(store[GPIO_CFG_BASE_IDX + 8'(i)]);
				// Straps stay inputs until the window closes
				if (!strap_window) begin
					for (int r = 0; r < NUM_REFS; r++) begin
						if (f == FUNC_SIG_ABSENT_BASE + 7'(r * FUNC_SIG_ABSENT_STEP)) begin
							next_signal_absent_flag[r] = next_signal_absent_flag[r] | gpio_in[i];
						end
					end
					if (f == FUNC_HOST_IRQ) begin
						next_gpio_out[i] = irq;
						next_gpio_oe[i] = 1'b1;
					end
				end
				if (i == TEST_ENABLE_PIN && f == FUNC_PLAIN_INPUT) begin
					pin2_en = gpio_in[i];
				end
			end
			next_first_hp_diff_output = store[OUT_EN_IDX];
			next_first_hp_diff_output[0] = store[OUT_EN_IDX][0] | pin2_en;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			signal_absent_flag <= '0;
			gpio_out <= '0;
			gpio_oe <= '0;
			first_hp_diff_output <= '0;
			config_ready <= 1'b0;
		end else begin
			signal_absent_flag <= next_signal_absent_flag;
			gpio_out <= next_gpio_out;
			gpio_oe <= next_gpio_oe;
			first_hp_diff_output <= next_first_hp_diff_output;
			config_ready <= running;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status: sticky, write one to clear, set wins over clear
	always_comb begin
		// Signal-loss bits catch rising edges, so a steady fault flags once
		irq_set = '0;
		irq_set[IRQ_SIG_ABSENT_LSB +: NUM_REFS] = next_signal_absent_flag & ~signal_absent_flag;
		irq_set[IRQ_LOAD_DONE] = running && !config_ready;
		irq_set[IRQ_STRAP_DONE] = strap_window && !next_strap_window;
		irq_set[IRQ_MCLK_RSVD] = strap_window && !next_strap_window && !next_mclk_valid;
		irq_set[IRQ_HOST_WRITE] = host_wr;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		if (acc && running && apb_req.pwrite && apb_req.paddr == IRQ_STATUS_ADDR) begin
			next_irq_status = irq_status & ~apb_req.pwdata[7:0];
		end
		if (acc && running && apb_req.pwrite && apb_req.paddr == IRQ_MASK_ADDR) begin
			next_irq_mask = apb_req.pwdata[7:0];
		end
		next_irq_status = next_irq_status | irq_set;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status <= '0;
			irq_mask <= IRQ_MASK_RST;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB read data, sampled every selected cycle
	always_comb begin
		next_prdata = '0;
		if (store_hit) begin
			next_prdata = {24'h000000, store[host_idx]};
		end else if (apb_req.paddr == IRQ_STATUS_ADDR) begin
			next_prdata = {24'h000000, irq_status};
		end else if (apb_req.paddr == IRQ_MASK_ADDR) begin
			next_prdata = {24'h000000, irq_mask};
		end else if (apb_req.paddr == STRAP_STAT_ADDR) begin
			// Status byte: b7 clock select valid, b6 window open, low bits straps
			next_prdata = 32'({mclk_valid, strap_window, strap_bits});
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata_q <= '0;
		end else if (apb_req.psel) begin
			prdata_q <= next_prdata;
		end
	end

	// Bus answer: held off while the loader runs
	always_comb begin
		apb_rsp.pready = acc && running;
		apb_rsp.pslverr = acc && running && !(store_hit || own_hit);
		apb_rsp.prdata = prdata_q;
	end

endmodule

/* File: hdl/rscg_pkg.sv */
// Package of constants and carrier types for the reset, strap and configuration loader
package rscg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int STRAP_HOLD_MS = 50;
	localparam int STRAP_HOLD_CYCLES = (STRAP_HOLD_MS * (CLK_HZ / 1000));
	localparam int STRAP_CNT_W = 21;

	////////////////////////////////////////////////////////////////////////////
	// Configuration store
	localparam int STORE_DEPTH = 253;
	localparam logic [7:0] STORE_LAST_IDX = 8'hFC;
	localparam logic [7:0] STORE_RST_VAL = 8'h00;
	localparam logic [7:0] OUT_EN_IDX = 8'h40;
	localparam logic [7:0] GPIO_CFG_BASE_IDX = 8'hE0;
	localparam int GPIO_FUNC_MSB = 6;

	////////////////////////////////////////////////////////////////////////////
	// Pin function codes
	localparam logic [6:0] FUNC_PLAIN_INPUT = 7'h00;
	localparam logic [6:0] FUNC_HOST_IRQ = 7'h01;
	localparam logic [6:0] FUNC_SIG_ABSENT_BASE = 7'h10;
	localparam int FUNC_SIG_ABSENT_STEP = 4;
	localparam int NUM_REFS = 4;

	////////////////////////////////////////////////////////////////////////////
	// Straps
	localparam logic [1:0] MCLK_SEL_24M576 = 2'h3;
	localparam int TEST_ENABLE_PIN = 2;

	////////////////////////////////////////////////////////////////////////////
	// APB map: store register i sits at byte 4*i
	localparam logic [11:0] IRQ_STATUS_ADDR = 12'h400;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h404;
	localparam logic [11:0] STRAP_STAT_ADDR = 12'h408;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;

	// Interrupt status bit positions
	localparam int IRQ_SIG_ABSENT_LSB = 0;
	localparam int IRQ_LOAD_DONE = 4;
	localparam int IRQ_STRAP_DONE = 5;
	localparam int IRQ_MCLK_RSVD = 6;
	localparam int IRQ_HOST_WRITE = 7;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		LD_FETCH = 2'b00,
		LD_LAST = 2'b01,
		LD_RUN = 2'b11
	} rscg_ld_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rscg_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rscg_apb_rsp_t;

endpackage

/* File: verif/rscg_properties.sv */
// Concurrent checks on the loader top ports
`timescale 1ns/1ps
module rscg_properties
	import rscg_pkg::*;
#(
	parameter int STRAP_CYCLES = 20,
	parameter int NUM_GPIO = 6
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus
	input wire rscg_pkg::rscg_apb_req_t apb_req,
	input wire rscg_pkg::rscg_apb_rsp_t apb_rsp,
	// Pins and block outputs
	input wire logic [NUM_GPIO-1:0] gpio_in,
	input wire logic [NUM_GPIO-1:0] gpio_out,
	input wire logic [NUM_GPIO-1:0] gpio_oe,
	input wire logic [7:0] first_hp_diff_output,
	input wire logic config_ready,
	input wire logic strap_window,
	input wire logic [NUM_GPIO-1:0] strap_bits,
	input wire logic mclk_valid,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// Start-up steps
	sequence s_release;
		$fell(rst);
	endsequence
	sequence s_close;
		$fell(strap_window);
	endsequence

	a_outputs_off: assert property (s_release |-> first_hp_diff_output == 8'h00)
		else $error("outputs enabled at release");
	a_load_time: assert property (s_release |-> !config_ready[*8] ##[1:300] config_ready)
		else $error("store load did not finish");
	a_ready_sticky: assert property (config_ready |=> config_ready)
		else $error("ready dropped");
	a_strap_latch: assert property (s_close |-> strap_bits == $past(gpio_in))
		else $error("strap levels not latched");
	a_mclk_select: assert property (s_close |-> mclk_valid == ($past(gpio_in[1:0]) == 2'h3))
		else $error("master clock select wrong");
	a_strap_frozen: assert property (!strap_window && !$fell(strap_window) |-> $stable(strap_bits))
		else $error("straps changed after window");
	a_pin2_enable: assert property (config_ready && !strap_window && gpio_in[2] |=> first_hp_diff_output[0])
		else $error("pin 2 did not enable output");
	a_irq_pin: assert property (gpio_oe[3] && $past(gpio_oe[3]) |-> gpio_out[3] == $past(irq))
		else $error("irq pin does not follow irq");
	a_bus_ready: assert property (config_ready && apb_req.psel && apb_req.penable |-> apb_rsp.pready)
		else $error("bus stalled after load");
	a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr[11:2] == 10'h0FD |->
		apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
		else $error("index 253 not refused");
endmodule

bind rscg_top rscg_properties #(.STRAP_CYCLES(STRAP_CYCLES), .NUM_GPIO(NUM_GPIO)) i_rscg_properties (
	.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .first_hp_diff_output(first_hp_diff_output),
	.config_ready(config_ready), .strap_window(strap_window), .strap_bits(strap_bits),
	.mclk_valid(mclk_valid), .irq(irq)
);

/* File: verif/rscg_otp_model.sv */
// Image memory model answering the loader's read port in the same cycle
`timescale 1ns/1ps
module rscg_otp_model (
	// Image read port
	input wire logic [7:0] otp_addr,
	output logic [7:0] otp_rdata
);
	// Low block patterned, rest zero so outputs and pins stay off after load
	assign otp_rdata = (otp_addr < 8'h40) ? (otp_addr ^ 8'h3C) : 8'h00;
endmodule

/* File: verif/reset_strap_config_gpio_map_test.sv */
// Self-checking bench for the reset, strap and configuration loader
`timescale 1ns/1ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin failures++; \
	$display("CHECK FAILED at %0t got %0h exp %0h", $time, (g), (x)); end end
module reset_strap_config_gpio_map_test;
	import rscg_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic otp_custom = 1'b0;
	rscg_apb_req_t req = '0;
	rscg_apb_rsp_t rsp;
	logic [7:0] otp_addr, otp_rdata, first_hp_diff_output;
	logic [5:0] gpio_in = 6'h00;
	logic [5:0] gpio_out, gpio_oe, strap_bits;
	logic [3:0] signal_absent_flag;
	logic config_ready, strap_window, mclk_valid, irq;
	int failures = 0;
	int samples_checked = 0;

	// Design with a short strap window, and the image memory
	rscg_top #(.STRAP_CYCLES(20), .NUM_GPIO(6)) i_rscg_top (.ref_clk(ref_clk), .rst(rst), .apb_req(req),
		.apb_rsp(rsp), .otp_custom(otp_custom), .otp_addr(otp_addr), .otp_rdata(otp_rdata),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .first_hp_diff_output(first_hp_diff_output),
		.signal_absent_flag(signal_absent_flag), .config_ready(config_ready), .strap_window(strap_window),
		.strap_bits(strap_bits), .mclk_valid(mclk_valid), .irq(irq));
	rscg_otp_model i_rscg_otp_model (.otp_addr(otp_addr), .otp_rdata(otp_rdata));

	always #20 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic summarize();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic boot(input logic [5:0] g, input logic c);
		int n;
		@(posedge ref_clk);
		rst <= 1'b1;
		gpio_in <= g;
		otp_custom <= c;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		n = 0;
		while (config_ready !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 400) begin
			failures++;
			summarize();
		end
	endtask
	// Setup then access phase, held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
		int n;
		@(posedge ref_clk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 400);
		r = {rsp.pslverr, rsp.prdata};
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (rsp.pready !== 1'b1) begin
			failures++;
			summarize();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		logic [32:0] r;
		xfer(1'b0, a, 32'h0, r);
		`CHK(r, x)
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_defaults();
		boot(6'h0B, 1'b0);
		`CHK(first_hp_diff_output, 8'h00)
		`CHK({mclk_valid, strap_bits}, 7'h4B)
		rd(12'h014, 33'h0);
		rd(STRAP_STAT_ADDR, 33'h8B);
		gpio_in <= 6'h30;
		tick(2);
		`CHK(strap_bits, 6'h0B)
		$display("defaults test done");
	endtask
	task automatic t_image();
		boot(6'h01, 1'b1);
		`CHK(mclk_valid, 1'b0)
		rd(12'h014, 33'h39);
		rd(12'h0FC, 33'h03);
		rd(IRQ_STATUS_ADDR, 33'h70);
		gpio_in <= 6'h04;
		tick(1);
		`CHK(first_hp_diff_output[0], 1'b1)
		$display("image test done");
	endtask
	task automatic t_host();
		@(posedge ref_clk);
		gpio_in <= 6'h00;
		wr(12'h100, 32'h06);
		tick(1);
		`CHK(first_hp_diff_output, 8'h06)
		rd(12'h100, 33'h06);
		wr(12'h3F4, 32'hFF);
		rd(12'h3F4, 33'h1_0000_0000);
		wr(12'h3F0, 32'hA5);
		rd(12'h3F0, 33'hA5);
		$display("host test done");
	endtask
	task automatic t_irq();
		wr(IRQ_STATUS_ADDR, 32'hFF);
		wr(IRQ_MASK_ADDR, 32'h02);
		wr(12'h390, 32'h94);
		wr(12'h38C, 32'h01);
		tick(2);
		`CHK({irq, gpio_oe}, 7'h08)
		rd(IRQ_STATUS_ADDR, 33'h80);
		gpio_in <= 6'h10;
		tick(4);
		`CHK({signal_absent_flag, irq, gpio_out[3]}, 6'h0B)
		rd(IRQ_STATUS_ADDR, 33'h82);
		wr(IRQ_STATUS_ADDR, 32'h02);
		tick(2);
		`CHK(irq, 1'b0)
		wr(12'h390, 32'h00);
		tick(2);
		`CHK(signal_absent_flag, 4'h0)
		wr(12'h380, 32'h10);
		wr(12'h390, 32'h18);
		wr(12'h394, 32'h1C);
		gpio_in <= 6'h31;
		tick(2);
		`CHK(signal_absent_flag, 4'hD)
		rd(IRQ_STATUS_ADDR, 33'h8D);
		$display("interrupt test done");
	endtask

	initial begin
		t_defaults();
		t_image();
		t_host();
		t_irq();
		summarize();
	end
endmodule
